// ===== logic/can_msg_object_page_status.sv
// Message object page, control, status and bit timing registers with bus sampling.
// Assumes a frame engine on core_clk_i supplies frame phase and completion strobes.
`timescale 1ns/1ps
`include "can_obj_defines.svh"
module can_msg_object_page_status (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        controller_enable_i,
	input  wire logic        can_rx_i,
	input  wire logic        frame_active_i,
	input  wire logic        tx_active_i,
	input  wire logic        tx_bit_i,
	input  wire logic        arb_field_i,
	input  wire logic        error_frame_i,
	input  wire logic        ack_slot_i,
	input  wire logic        fixed_form_i,
	input  wire logic        crc_calc_i,
	input  wire logic        crc_recv_i,
	input  wire logic        crc_check_i,
	input  wire logic [3:0]  err_obj_i,
	input  wire logic        tx_done_i,
	input  wire logic        rx_done_i,
	input  wire logic [14:0] rx_hit_i,
	input  wire logic [3:0]  rx_dlc_i,
	output logic             sampled_bit_o,
	output logic             sample_point_o,
	output logic      [3:0]  tx_select_o,
	output logic             tx_pending_o,
	output logic      [14:0] obj_irq_o
);
	// Bus sampling and bit segment state.
	logic [1:0]              rx_sync_reg;
	logic                    rx_prev_reg,   rx_prev_next;
	logic [1:0]              hist_reg,      hist_next;
	logic [5:0]              presc_reg,     presc_next;
	logic [2:0]              cnt_reg,       cnt_next;
	logic                    ext_reg,       ext_next;
	can_obj_pkg::seg_state_t seg_reg,       seg_next;
	logic                    smp_bit_reg,   smp_bit_next;
	logic                    smp_pt_reg,    smp_pt_next;
	// Register file state.
	logic [7:0]              page_reg,      page_next;
	logic [7:0]              bt1_reg,       bt1_next;
	logic [7:0]              bt3_reg,       bt3_next;
	logic [7:0]              rdata_reg,     rdata_next;
	logic [7:0]              data_reg [120];
	logic [7:0]              data_next [120];
	logic [7:0]              st_reg [15];
	logic [7:0]              st_next [15];
	logic [7:0]              ctl_reg [15];
	logic [7:0]              ctl_next [15];
	logic [14:0]             irq_reg;
	logic [3:0]              txsel_reg,     txsel_next;
	logic                    txpend_reg,    txpend_next;
	// Error detection state.
	logic [2:0]              same_reg,      same_next;
	logic                    last_reg,      last_next;
	logic [14:0]             crc_reg,       crc_next;
	logic [14:0]             rcrc_reg,      rcrc_next;
	logic [4:0]              err_set;
	logic                    rx_s, edge_fall, tq_tick, half_tick, maj;
	logic [5:0]              half_cnt;
	logic [3:0]              obj, rx_sel;
	logic [2:0]              idx;
	logic                    obj_ok, data_acc, rx_ok;
	logic [6:0]              data_ptr;

	assign rx_s      = rx_sync_reg[1];
	assign edge_fall = rx_prev_reg & ~rx_s;
	assign half_cnt  = 6'((7'(bt1_reg[6:1]) + 7'h01) >> 1);
	assign tq_tick   = (presc_reg == 6'h00);
	assign half_tick = (presc_reg == half_cnt);
	assign maj       = (rx_s & hist_reg[0]) | (rx_s & hist_reg[1]) | (hist_reg[0] & hist_reg[1]);
	assign obj       = page_reg[7:4];
	assign idx       = page_reg[2:0];
	assign obj_ok    = (obj != 4'hf);
	assign data_ptr  = {obj[3:0], idx};
	assign data_acc  = (sfr_addr_i == `OFS_DATA) & (sfr_rd_i | sfr_wr_i) & obj_ok;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_sync_reg <= 2'h3;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], can_rx_i};
		end
	end

	// Quantum prescaler, phase segments, resynchronisation and sample point.
	always_comb begin
		presc_next   = tq_tick ? bt1_reg[6:1] : 6'(presc_reg - 6'h01);
		hist_next    = (tq_tick | half_tick) ? {hist_reg[0], rx_s} : hist_reg;
		rx_prev_next = rx_s;
		seg_next     = seg_reg;
		cnt_next     = cnt_reg;
		ext_next     = ext_reg;
		smp_pt_next  = 1'b0;
		smp_bit_next = smp_bit_reg;
		case (seg_reg)
			can_obj_pkg::SEG_SYNC: begin
				if (tq_tick) begin
					seg_next = can_obj_pkg::SEG_ONE;
					cnt_next = bt3_reg[3:1];
					ext_next = 1'b0;
				end
			end
			can_obj_pkg::SEG_ONE: begin
				if (tq_tick && cnt_reg == 3'h0 && !ext_reg) begin
					seg_next     = can_obj_pkg::SEG_TWO;
					cnt_next     = bt3_reg[6:4];
					smp_pt_next  = 1'b1;
					smp_bit_next = bt3_reg[0] ? maj : rx_s;
				end else if (tq_tick && cnt_reg == 3'h0) begin
					ext_next = 1'b0;
				end else if (tq_tick) begin
					cnt_next = cnt_reg - 3'h1;
				end
				if (edge_fall && !(tq_tick && cnt_reg == 3'h0)) begin
					ext_next = 1'b1;
				end
			end
			can_obj_pkg::SEG_TWO: begin
				if (edge_fall) begin
					seg_next   = can_obj_pkg::SEG_SYNC;
					presc_next = bt1_reg[6:1];
				end else if (tq_tick && cnt_reg == 3'h0) begin
					seg_next = can_obj_pkg::SEG_SYNC;
				end else if (tq_tick) begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			default: begin
				seg_next = can_obj_pkg::SEG_SYNC;
			end
		endcase
		if (!controller_enable_i) begin
			seg_next    = can_obj_pkg::SEG_SYNC;
			presc_next  = bt1_reg[6:1];
			smp_pt_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			presc_reg   <= 6'h00;
			hist_reg    <= 2'h3;
			rx_prev_reg <= 1'b1;
			seg_reg     <= can_obj_pkg::SEG_SYNC;
			cnt_reg     <= 3'h0;
			ext_reg     <= 1'b0;
			smp_pt_reg  <= 1'b0;
			smp_bit_reg <= 1'b1;
		end else begin
			presc_reg   <= presc_next;
			hist_reg    <= hist_next;
			rx_prev_reg <= rx_prev_next;
			seg_reg     <= seg_next;
			cnt_reg     <= cnt_next;
			ext_reg     <= ext_next;
			smp_pt_reg  <= smp_pt_next;
			smp_bit_reg <= smp_bit_next;
		end
	end

	// Bit, stuff, CRC, form and acknowledge checks on each sampled bit.
	always_comb begin
		same_next = same_reg;
		last_next = last_reg;
		crc_next  = crc_reg;
		rcrc_next = rcrc_reg;
		err_set   = 5'h00;
		if (!frame_active_i) begin
			same_next = 3'h0;
			crc_next  = 15'h0000;
			rcrc_next = 15'h0000;
		end else if (smp_pt_reg) begin
			last_next = smp_bit_reg;
			same_next = (same_reg != 3'h0 && smp_bit_reg == last_reg) ?
			            3'(same_reg + 3'h1) : 3'h1;
			if (same_reg == 3'h5 && smp_bit_reg == last_reg) begin
				err_set[`ST_STUFF_ERROR_FLAG] = 1'b1;
				same_next         = 3'h1;
			end
			if (crc_calc_i) begin
				crc_next = {crc_reg[13:0], 1'b0} ^
				           ((smp_bit_reg ^ crc_reg[14]) ? `CRC_POLY : 15'h0000);
			end
			if (crc_recv_i) begin
				rcrc_next = {rcrc_reg[13:0], smp_bit_reg};
			end
			err_set[`ST_CRC_ERROR_FLAG] = crc_check_i & (crc_reg != rcrc_reg);
			err_set[`ST_FORM_ERROR_FLAG] = fixed_form_i & ~smp_bit_reg;
			err_set[`ST_ACK_ERROR_FLAG] = tx_active_i & ack_slot_i & ~error_frame_i & smp_bit_reg;
			err_set[`ST_BIT_ERROR_FLAG] = tx_active_i & (smp_bit_reg != tx_bit_i) &
			                    ~(arb_field_i & tx_bit_i) & ~(error_frame_i & ack_slot_i);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			same_reg <= 3'h0;
			last_reg <= 1'b1;
			crc_reg  <= 15'h0000;
			rcrc_reg <= 15'h0000;
		end else begin
			same_reg <= same_next;
			last_reg <= last_next;
			crc_reg  <= crc_next;
			rcrc_reg <= rcrc_next;
		end
	end

	// Page, timing and data registers with registered read answer.
	always_comb begin
		page_next  = page_reg;
		bt1_next   = bt1_reg;
		bt3_next   = bt3_reg;
		rdata_next = rdata_reg;
		data_next  = data_reg;
		if (sfr_wr_i && sfr_addr_i == `OFS_PAGE) begin
			page_next = sfr_wdata_i;
		end
		if (sfr_wr_i && !controller_enable_i && sfr_addr_i == `OFS_TIMING1) begin
			bt1_next = sfr_wdata_i & `MASK_TIMING1;
		end
		if (sfr_wr_i && !controller_enable_i && sfr_addr_i == `OFS_TIMING3) begin
			bt3_next = sfr_wdata_i & `MASK_TIMING3;
		end
		if (sfr_wr_i && data_acc) begin
			data_next[data_ptr] = sfr_wdata_i;
		end
		if (data_acc && !page_reg[`PAGE_HOLD]) begin
			page_next[2:0] = idx + 3'h1;
		end
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				`OFS_PAGE:    rdata_next = page_reg;
				`OFS_STATUS:  rdata_next = obj_ok ? st_reg[obj] : 8'h00;
				`OFS_CTRL:    rdata_next = obj_ok ? ctl_reg[obj] : 8'h00;
				`OFS_TIMING1: rdata_next = bt1_reg;
				`OFS_TIMING3: rdata_next = bt3_reg;
				`OFS_DATA:    rdata_next = obj_ok ? data_reg[data_ptr] : 8'h00;
				default:      rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			page_reg  <= `RST_PAGE;
			bt1_reg   <= `RST_TIMING;
			bt3_reg   <= `RST_TIMING;
			rdata_reg <= 8'h00;
			for (int k = 0; k < 120; k++) begin
				data_reg[k] <= 8'h00;
			end
		end else begin
			page_reg  <= page_next;
			bt1_reg   <= bt1_next;
			bt3_reg   <= bt3_next;
			rdata_reg <= rdata_next;
			data_reg  <= data_next;
		end
	end

	// Lowest pending transmitter and lowest receive hit win.
	always_comb begin
		txsel_next  = 4'h0;
		txpend_next = 1'b0;
		rx_sel      = 4'h0;
		rx_ok       = |rx_hit_i;
		for (int k = `OBJ_COUNT - 1; k >= 0; k--) begin
			if (ctl_reg[k][7:6] == can_obj_pkg::CFG_TX) begin
				txsel_next  = 4'(k);
				txpend_next = 1'b1;
			end
			if (rx_hit_i[k]) begin
				rx_sel = 4'(k);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			txsel_reg  <= 4'h0;
			txpend_reg <= 1'b0;
		end else begin
			txsel_reg  <= txsel_next;
			txpend_reg <= txpend_next;
		end
	end

	// Per-object control and sticky status; hardware sets win over software writes.
	for (genvar i = 0; i < `OBJ_COUNT; i++) begin : g_obj
		always_comb begin
			st_next[i]  = st_reg[i];
			ctl_next[i] = ctl_reg[i];
			if (sfr_wr_i && obj == 4'(i) && sfr_addr_i == `OFS_STATUS) begin
				st_next[i] = sfr_wdata_i;
			end
			if (sfr_wr_i && obj == 4'(i) && sfr_addr_i == `OFS_CTRL) begin
				ctl_next[i] = sfr_wdata_i;
			end
			if (rx_done_i && rx_ok && rx_sel == 4'(i)) begin
				ctl_next[i][3:0]     = rx_dlc_i;
				st_next[i][`ST_RECEIVE_DONE_FLAG] = 1'b1;
				if (rx_dlc_i != ctl_reg[i][3:0]) begin
					st_next[i][`ST_LENGTH_MISMATCH_FLAG] = 1'b1;
				end
			end
			if (tx_done_i && txpend_reg && txsel_reg == 4'(i)) begin
				st_next[i][`ST_TRANSMIT_DONE_FLAG] = 1'b1;
			end
			if (err_obj_i == 4'(i)) begin
				st_next[i][4:0] = st_next[i][4:0] | err_set;
			end
		end
		always_ff @(posedge core_clk_i) begin
			if (!rst_n_i) begin
				st_reg[i]  <= `RST_OBJ;
				ctl_reg[i] <= `RST_OBJ;
				irq_reg[i] <= 1'b0;
			end else begin
				st_reg[i]  <= st_next[i];
				ctl_reg[i] <= ctl_next[i];
				irq_reg[i] <= |st_next[i][6:0];
			end
		end
	end

	assign sfr_rdata_o    = rdata_reg;
	assign sampled_bit_o  = smp_bit_reg;
	assign sample_point_o = smp_pt_reg;
	assign tx_select_o    = txsel_reg;
	assign tx_pending_o   = txpend_reg;
	assign obj_irq_o      = irq_reg;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_index_step: assert property (data_acc && !page_reg[3] && !(sfr_wr_i && sfr_addr_i == `OFS_PAGE)
		|=> page_reg[2:0] == 3'($past(page_reg[2:0]) + 3'h1)) else $error("index did not step");
	a_index_hold: assert property (data_acc && page_reg[3] && !(sfr_wr_i && sfr_addr_i == `OFS_PAGE)
		|=> $stable(page_reg[2:0])) else $error("held index moved");
	a_object_range: assert property (sfr_rd_i && sfr_addr_i == `OFS_STATUS && obj == 4'hf
		|=> sfr_rdata_o == 8'h00) else $error("object 15 answered");
	a_timing_locked: assert property (controller_enable_i && sfr_wr_i && sfr_addr_i == `OFS_TIMING3
		|=> $stable(bt3_reg)) else $error("timing changed while enabled");
	a_rx_length: assert property (rx_done_i && rx_ok
		|=> ctl_reg[$past(rx_sel)][3:0] == $past(rx_dlc_i) && st_reg[$past(rx_sel)][5])
		else $error("receive not recorded");
	a_length_warn: assert property (rx_done_i && rx_ok && rx_dlc_i != ctl_reg[rx_sel][3:0]
		|=> st_reg[$past(rx_sel)][7]) else $error("length warning missing");
	a_tx_flag: assert property (tx_done_i && txpend_reg
		|=> st_reg[$past(txsel_reg)][6] ##1 irq_reg[$past(txsel_reg, 2)])
		else $error("transmit flag or request missing");
	a_ack_flag: assert property (frame_active_i && smp_pt_reg && tx_active_i && ack_slot_i
		&& !error_frame_i && smp_bit_reg && err_obj_i < 4'hf
		|=> st_reg[$past(err_obj_i)][0]) else $error("ack error missing");
	a_form_flag: assert property (frame_active_i && smp_pt_reg && fixed_form_i && !smp_bit_reg
		&& err_obj_i < 4'hf |=> st_reg[$past(err_obj_i)][1]) else $error("form error missing");
	a_sample_once: assert property (smp_pt_reg |=> !smp_pt_reg)
		else $error("sample point longer than a cycle");
	a_stuff_count: assert property (same_reg <= 3'h5) else $error("stuff count overran");

	c_rx_done: cover property (rx_done_i && rx_ok ##1 st_reg[rx_sel][7]);
	c_tx_done: cover property (tx_done_i && txpend_reg);
	c_stuff: cover property (err_set[3]);
	c_triple: cover property (smp_pt_reg && bt3_reg[0]);
endmodule // can_msg_object_page_status

// ===== pkg/can_obj_defines.svh
// Register offsets, field positions, reset values and counts of the message object block.
// Assumes the including file is compiled after the package can_obj_pkg.
//
// Summary of operation
// - Bits 6..4 of timing register three give phase two length in quanta, minus one.
// - Bits 3..1 of timing register three give phase one length in quanta, minus one.
// - Sample type 0 samples once; 1 takes majority of three half-quantum samples.
// - Page bits 7..4 select message object 0 to 14 for object registers.
// - Page bit 3 low makes the byte index step on each data access.
// - Page bits 2..0 select the byte of the object's eight-byte data field.
// - Configuration field bits 7..6: off, transmit, receive, receive buffer.
// - Bit 5 marks an automatic reply as ready and valid.
// - Bit 4 selects an 11-bit or a 29-bit identifier for the object.
// - Length code holds 0 to 8 bytes and is overwritten by each received frame.
// - Status bit 7 flags a received length differing from the stored one.
// - Status bit 6 flags transmit done; lowest pending object is sent first.
// - Status bit 5 flags receive done; only the lowest hit object is updated.
// - Status bit 4 flags a transmit bit error, except a sent recessive arbitration bit and error-frame acknowledge.
// - Status bit 3 flags more than five equal consecutive bus bits.
// - Status bit 2 flags a computed CRC differing from the received CRC.
// - Status bit 1 flags an illegal delimiter or end-of-frame bit.
// - Status bit 0 flags a recessive acknowledge slot.
// - Every completion and error flag of an object can request an interrupt.
// - One quantum lasts prescaler field plus one core clocks.
`ifndef CAN_OBJ_DEFINES_SVH
`define CAN_OBJ_DEFINES_SVH
`define OFS_PAGE      8'hb1
`define OFS_STATUS    8'hb2
`define OFS_CTRL      8'hb3
`define OFS_TIMING1   8'hb4
`define OFS_TIMING3   8'hb6
`define OFS_DATA      8'hfa
`define RST_PAGE      8'h00
`define RST_OBJ       8'h00
`define RST_TIMING    8'h00
`define MASK_TIMING1  8'h7e
`define MASK_TIMING3  8'h7f
`define PAGE_HOLD     3
`define ST_LENGTH_MISMATCH_FLAG       7
`define ST_TRANSMIT_DONE_FLAG       6
`define ST_RECEIVE_DONE_FLAG       5
`define ST_BIT_ERROR_FLAG       4
`define ST_STUFF_ERROR_FLAG       3
`define ST_CRC_ERROR_FLAG       2
`define ST_FORM_ERROR_FLAG       1
`define ST_ACK_ERROR_FLAG       0
`define OBJ_COUNT     15
`define STUFF_LIMIT   3'h6
`define CRC_POLY      15'h4599
`endif

// ===== pkg/can_obj_pkg.sv
// Types shared by the message object block.
// Assumes nothing of its surroundings.
package can_obj_pkg;
	typedef enum logic [2:0] {
		SEG_SYNC = 3'b001,
		SEG_ONE  = 3'b010,
		SEG_TWO  = 3'b100
	} seg_state_t;
	typedef enum logic [1:0] {
		CFG_OFF   = 2'b00,
		CFG_TX    = 2'b01,
		CFG_RX    = 2'b10,
		CFG_RXBUF = 2'b11
	} obj_cfg_t;
endpackage

// ===== verif/can_bus_node.sv
// Model of another node on the shared bus that drives the receive pin.
// Assumes one core clock; the idle bus rests recessive (1), as a pull-up leaves it.
`timescale 1ns/1ps
module can_bus_node #(
	parameter int BIT_CLKS = 10
) (
	input  wire logic clk_i,
	output logic      bus_o
);
	initial bus_o = 1'b1;

	// Drives a level for n bit times, then releases the bus to recessive.
	task automatic drive(input logic lvl, input int n);
		@(negedge clk_i);
		bus_o = lvl;
		repeat (n * BIT_CLKS) @(negedge clk_i);
		bus_o = 1'b1;
	endtask
endmodule // can_bus_node

// ===== verif/can_msg_object_page_status_test.sv
// Self-checking bench for the message object page, status and timing block.
// Assumes the design files and a bus node model; inputs change at the falling edge.
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
		end \
	end
module can_msg_object_page_status_test;
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        ena   = 1'b0;
	logic        fa    = 1'b0;
	logic        txa   = 1'b0;
	logic        txb   = 1'b0;
	logic        arb   = 1'b0;
	logic        ack   = 1'b0;
	logic        ff    = 1'b0;
	logic [3:0]  eobj  = 4'h4;
	logic        txd   = 1'b0;
	logic        rxd   = 1'b0;
	logic [14:0] hit   = 15'h0000;
	logic [3:0]  dlc   = 4'h0;
	logic [7:0]  rdata;
	logic        rx;
	logic        sbit;
	logic        spt;
	logic [3:0]  tsel;
	logic        tpend;
	logic [14:0] irq;
	int          miscompares  = 0;
	int          total_checks = 0;
	int          c;

	initial begin
		forever #25 clk = ~clk;
	end

	can_msg_object_page_status i_can_msg_object_page_status (
		.core_clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .controller_enable_i(ena),
		.can_rx_i(rx), .frame_active_i(fa), .tx_active_i(txa), .tx_bit_i(txb),
		.arb_field_i(arb), .error_frame_i(1'b0), .ack_slot_i(ack), .fixed_form_i(ff),
		.crc_calc_i(1'b0), .crc_recv_i(1'b0), .crc_check_i(1'b0), .err_obj_i(eobj),
		.tx_done_i(txd), .rx_done_i(rxd), .rx_hit_i(hit), .rx_dlc_i(dlc),
		.sampled_bit_o(sbit), .sample_point_o(spt), .tx_select_o(tsel),
		.tx_pending_o(tpend), .obj_irq_o(irq)
	);

	can_bus_node #(.BIT_CLKS(10)) i_can_bus_node (.clk_i(clk), .bus_o(rx));

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		`CHK(rdata, e)
	endtask

	// Counts clocks between two sample point pulses.
	task automatic gap(output int n);
		int t;
		t = 0;
		while (spt !== 1'b1 && t < 200) begin
			@(negedge clk);
			t++;
		end
		n = 1;
		@(negedge clk);
		while (spt !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		`CHK(sbit, 1'b1)
		`CHK(irq, 15'h0000)
		rd_chk(8'hb1, 8'h00);
		rd_chk(8'hb2, 8'h00);
		rd_chk(8'hb3, 8'h00);
		rd_chk(8'hb6, 8'h00);
		rd_chk(8'h80, 8'h00);
		$display("test reset done");
		wr_reg(8'hb1, 8'h20);
		wr_reg(8'hfa, 8'h55);
		wr_reg(8'hfa, 8'h66);
		wr_reg(8'hb1, 8'h27);
		wr_reg(8'hfa, 8'haa);
		rd_chk(8'hfa, 8'h55);
		rd_chk(8'hfa, 8'h66);
		wr_reg(8'hb1, 8'h2f);
		rd_chk(8'hfa, 8'haa);
		rd_chk(8'hfa, 8'haa);
		rd_chk(8'hb1, 8'h2f);
		wr_reg(8'hb1, 8'hf0);
		wr_reg(8'hb3, 8'hff);
		rd_chk(8'hb3, 8'h00);
		$display("test page done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'hb1, {i[3:0], 4'h8});
			wr_reg(8'hb3, {i[1:0], 1'b1, i[0], 4'(i + 4)});
		end
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'hb1, {i[3:0], 4'h8});
			rd_chk(8'hb3, {i[1:0], 1'b1, i[0], 4'(i + 4)});
		end
		wr_reg(8'hb1, 8'h58);
		wr_reg(8'hb3, 8'h40);
		@(negedge clk);
		`CHK(tsel, 4'h1)
		`CHK(tpend, 1'b1)
		txd = 1'b1;
		@(negedge clk);
		txd = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(irq, 15'h0002)
		wr_reg(8'hb1, 8'h18);
		rd_chk(8'hb2, 8'h40);
		hit = 15'h000c;
		dlc = 4'h8;
		rxd = 1'b1;
		@(negedge clk);
		rxd = 1'b0;
		hit = 15'h0000;
		wr_reg(8'hb1, 8'h28);
		rd_chk(8'hb3, 8'ha8);
		rd_chk(8'hb2, 8'ha0);
		wr_reg(8'hb1, 8'h38);
		rd_chk(8'hb2, 8'h00);
		rd_chk(8'hb3, 8'hf7);
		$display("test objects done");
		wr_reg(8'hb4, 8'hff);
		rd_chk(8'hb4, 8'h7e);
		wr_reg(8'hb4, 8'h02);
		wr_reg(8'hb6, 8'h12);
		ena = 1'b1;
		gap(c);
		`CHK(c, 10)
		ena = 1'b0;
		wr_reg(8'hb6, 8'h25);
		ena = 1'b1;
		gap(c);
		`CHK(c, 14)
		wr_reg(8'hb6, 8'h7f);
		rd_chk(8'hb6, 8'h25);
		fork
			i_can_bus_node.drive(1'b0, 3);
			begin
				repeat (25) @(negedge clk);
				`CHK(sbit, 1'b0)
			end
		join
		$display("test timing done");
		wr_reg(8'hb1, 8'h48);
		fa = 1'b1;
		txa = 1'b1;
		txb = 1'b1;
		arb = 1'b1;
		ff = 1'b1;
		i_can_bus_node.drive(1'b0, 3);
		ff = 1'b0;
		fa = 1'b0;
		rd_chk(8'hb2, 8'h02);
		arb = 1'b0;
		fa = 1'b1;
		i_can_bus_node.drive(1'b0, 9);
		fa = 1'b0;
		txa = 1'b0;
		rd_chk(8'hb2, 8'h1a);
		wr_reg(8'hb2, 8'h00);
		rd_chk(8'hb2, 8'h00);
		repeat (20) @(negedge clk);
		fa = 1'b1;
		txa = 1'b1;
		ack = 1'b1;
		repeat (30) @(negedge clk);
		ack = 1'b0;
		txa = 1'b0;
		fa = 1'b0;
		rd_chk(8'hb2, 8'h01);
		`CHK(irq[4], 1'b1)
		$display("test errors done");
		print_verdict();
	end
endmodule // can_msg_object_page_status_test
